// ---- core/fhv_pkg.sv ----
// shared constants and carrier types for the flash control register gate
package fhv_pkg;

    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [16:0] FHV_MODE_CTRL_ADDR = 17'h0FF80;
    localparam logic [16:0] FHV_ERASE_LO_ADDR = 17'h0FF82;
    localparam logic [16:0] FHV_ERASE_HI_ADDR = 17'h0FF83;

    // ------------------------------------------------------------
    // reset values and fixed read data
    // ------------------------------------------------------------
    localparam logic [7:0] FHV_MODE_CTRL_RST = 8'h80;
    localparam logic [7:0] FHV_ERASE_RST = 8'h00;
    localparam logic [7:0] FHV_RSVD_DATA = 8'hFF;

    // ------------------------------------------------------------
    // writer mode blank range, beyond the implemented array
    // ------------------------------------------------------------
    localparam logic [16:0] FHV_BLANK_LO = 17'h08000;
    localparam logic [16:0] FHV_BLANK_HI = 17'h1FFFF;

    // ------------------------------------------------------------
    // mode control field positions
    // ------------------------------------------------------------
    localparam int FHV_HV_BIT = 7;
    localparam int FHV_PROG_BIT = 0;
    localparam int FHV_ERASE_BIT = 1;
    localparam int FHV_PVER_BIT = 2;
    localparam int FHV_EVER_BIT = 3;
    localparam int FHV_CTRL_W = 7;

    // ------------------------------------------------------------
    // operating modes from the mode pins
    // ------------------------------------------------------------
    localparam logic [1:0] FHV_MODE1 = 2'h1;
    localparam logic [1:0] FHV_MODE2 = 2'h2;
    localparam logic [1:0] FHV_MODE3 = 2'h3;

    typedef enum logic [1:0] {
        FHV_AREA_REG,
        FHV_AREA_RSVD,
        FHV_AREA_EXT,
        FHV_AREA_MEM
    } fhv_area_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [16:0] addr;
        logic [7:0] wdata;
    } fhv_req_t;

    typedef struct packed {
        logic valid;
        logic ext;
        logic mem;
        logic [7:0] rdata;
    } fhv_rsp_t;

endpackage : fhv_pkg

// ---- core/fhv_reg.sv ----
// one gated control register with synchronous clear
`timescale 1ns/1ps
module fhv_reg #(
    parameter int W = 8,
    parameter logic [7:0] RST = 8'h00
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic clr,
    input wire logic we,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    generate
        if (W < 1 || W > 8) begin : g_bad_w
            $error("fhv_reg width must be 1 to 8");
        end
    endgenerate

    // clear outranks write: a register losing its supply never keeps new data
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= RST[W-1:0];
        end else if (clr) begin
            q <= RST[W-1:0];
        end else if (we) begin
            q <= d;
        end
    end
endmodule : fhv_reg

// ---- core/fhv_gate.sv ----
// flash control register gate: high-voltage flag, mode decode, standby
// What this block does
// - flag follows program-supply threshold detect
// - flag set permits control register writes
// - registers at FF80, FF82, FF83, need voltage
// - voltage present: modes 2,3 registers; mode 1 FF
// - no voltage: modes 1,2 external; mode 3 FF
// - writer mode reads beyond array return FF
// - low standby pin forces hardware standby
// - detect voltage by single comparator bit
`timescale 1ns/1ps
module fhv_gate (
    input wire logic clk,
    input wire logic nrst,
    input wire logic hv_detect,
    input wire logic standby_pin_n,
    input wire logic mode_select_pin_1,
    input wire logic mode_select_pin_0,
    input wire logic writer_mode,
    input wire fhv_pkg::fhv_req_t req,
    output fhv_pkg::fhv_rsp_t rsp_q,
    output logic hv_flag_q,
    output logic standby_q,
    output logic prog_en_q,
    output logic erase_en_q
);
    import fhv_pkg::*;

    // ------------------------------------------------------------
    // pin state
    // ------------------------------------------------------------
    logic [1:0] mode_q;

    // comparator output arrives already synchronous; one flop gives a clean flag
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hv_flag_q <= 1'b0;
        end else begin
            hv_flag_q <= hv_detect;
        end
    end

    // shared pin: low means standby in every mode, writer mode included
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            standby_q <= 1'b0;
        end else begin
            standby_q <= ~standby_pin_n;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= FHV_MODE3;
        end else begin
            mode_q <= {mode_select_pin_1, mode_select_pin_0};
        end
    end

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    logic hit_ctrl;
    logic hit_lo;
    logic hit_hi;
    logic hit_any;
    logic in_blank;
    fhv_area_t area;

    assign hit_ctrl = (req.addr == FHV_MODE_CTRL_ADDR);
    assign hit_lo = (req.addr == FHV_ERASE_LO_ADDR);
    assign hit_hi = (req.addr == FHV_ERASE_HI_ADDR);
    assign hit_any = hit_ctrl | hit_lo | hit_hi;
    assign in_blank = (req.addr >= FHV_BLANK_LO) && (req.addr <= FHV_BLANK_HI);

    always_comb begin
        area = FHV_AREA_MEM;
        if (writer_mode) begin
            area = in_blank ? FHV_AREA_RSVD : FHV_AREA_MEM;
        end else if (hit_any) begin
            if (hv_flag_q) begin
                case (mode_q)
                    FHV_MODE2: area = FHV_AREA_REG;
                    FHV_MODE3: area = FHV_AREA_REG;
                    default: area = FHV_AREA_RSVD;
                endcase
            end else begin
                case (mode_q)
                    FHV_MODE1: area = FHV_AREA_EXT;
                    FHV_MODE2: area = FHV_AREA_EXT;
                    default: area = FHV_AREA_RSVD;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    logic reg_wr;
    logic reg_clr;
    logic [FHV_CTRL_W-1:0] ctrl_q;
    logic [7:0] erase_lo_q;
    logic [7:0] erase_hi_q;
    logic [7:0] ctrl_byte;

    assign reg_wr = req.wr && !standby_q && (area == FHV_AREA_REG);
    // dropping the supply or entering standby wipes program and erase state,
    // so a stale program bit can never meet a returning supply
    assign reg_clr = standby_q || !hv_flag_q;

    fhv_reg #(
        .W(FHV_CTRL_W),
        .RST(FHV_MODE_CTRL_RST)
    ) u_ctrl (
        .clk(clk),
        .nrst(nrst),
        .clr(reg_clr),
        .we(reg_wr && hit_ctrl),
        .d(req.wdata[FHV_CTRL_W-1:0]),
        .q(ctrl_q)
    );

    fhv_reg #(
        .W(8),
        .RST(FHV_ERASE_RST)
    ) u_erase_lo (
        .clk(clk),
        .nrst(nrst),
        .clr(reg_clr),
        .we(reg_wr && hit_lo),
        .d(req.wdata),
        .q(erase_lo_q)
    );

    fhv_reg #(
        .W(8),
        .RST(FHV_ERASE_RST)
    ) u_erase_hi (
        .clk(clk),
        .nrst(nrst),
        .clr(reg_clr),
        .we(reg_wr && hit_hi),
        .d(req.wdata),
        .q(erase_hi_q)
    );

    // top bit mirrors the flag, so it reads one whenever registers are visible
    assign ctrl_byte = {hv_flag_q, ctrl_q};

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prog_en_q <= 1'b0;
            erase_en_q <= 1'b0;
        end else begin
            prog_en_q <= ctrl_q[FHV_PROG_BIT] && hv_flag_q && !standby_q;
            erase_en_q <= ctrl_q[FHV_ERASE_BIT] && hv_flag_q && !standby_q;
        end
    end

    // ------------------------------------------------------------
    // response
    // ------------------------------------------------------------
    fhv_rsp_t rsp_d;

    always_comb begin
        rsp_d = '0;
        rsp_d.valid = (req.rd || req.wr) && !standby_q;
        case (area)
            FHV_AREA_REG: begin
                if (hit_ctrl) begin
                    rsp_d.rdata = ctrl_byte;
                end else if (hit_lo) begin
                    rsp_d.rdata = erase_lo_q;
                end else begin
                    rsp_d.rdata = erase_hi_q;
                end
            end
            FHV_AREA_RSVD: rsp_d.rdata = FHV_RSVD_DATA;
            FHV_AREA_EXT: rsp_d.ext = rsp_d.valid;
            FHV_AREA_MEM: rsp_d.mem = rsp_d.valid;
            default: rsp_d.rdata = FHV_RSVD_DATA;
        endcase
        if (!req.rd) begin
            rsp_d.rdata = '0;
        end
    end

    // one cycle answer; standby swallows requests with no answer
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_hv_write_lo;
        req.wr && hit_lo && hv_flag_q && !standby_q && !writer_mode &&
            (mode_q == FHV_MODE2 || mode_q == FHV_MODE3) && hv_detect;
    endsequence

    sequence s_read_any;
        req.rd && !standby_q && !writer_mode && hit_any;
    endsequence

    property p_flag_follow;
        @(posedge clk) disable iff (!nrst)
        hv_detect ##1 hv_detect |=> hv_flag_q;
    endproperty

    flag_tracks_a: assert property (p_flag_follow)
        else $error("flag did not follow detect");

    write_accept_a: assert property (@(posedge clk) disable iff (!nrst)
        s_hv_write_lo |=> (erase_lo_q == $past(req.wdata)))
        else $error("erase select write lost");

    no_hv_locked_a: assert property (@(posedge clk) disable iff (!nrst)
        (!hv_flag_q && hit_any && !writer_mode) |=> (erase_lo_q == FHV_ERASE_RST)
            && (ctrl_q == FHV_MODE_CTRL_RST[FHV_CTRL_W-1:0]))
        else $error("registers changed without voltage");

    mode1_rsvd_a: assert property (@(posedge clk) disable iff (!nrst)
        (s_read_any and (hv_flag_q && mode_q == FHV_MODE1))
            |=> rsp_q.valid && !rsp_q.ext && rsp_q.rdata == FHV_RSVD_DATA)
        else $error("mode 1 with voltage not reserved");

    no_hv_ext_a: assert property (@(posedge clk) disable iff (!nrst)
        (s_read_any and (!hv_flag_q && (mode_q == FHV_MODE1 || mode_q == FHV_MODE2)))
            |=> rsp_q.ext && !rsp_q.mem)
        else $error("access not routed external");

    writer_blank_a: assert property (@(posedge clk) disable iff (!nrst)
        (req.rd && writer_mode && in_blank && !standby_q)
            |=> rsp_q.valid && rsp_q.rdata == FHV_RSVD_DATA)
        else $error("writer blank read not all ones");

    standby_quiet_a: assert property (@(posedge clk) disable iff (!nrst)
        !standby_pin_n ##1 !standby_pin_n |=> standby_q && !rsp_q.valid && !prog_en_q)
        else $error("standby not entered");

    mode3_top_bit_a: assert property (@(posedge clk) disable iff (!nrst)
        (s_read_any and (hit_ctrl && mode_q == FHV_MODE3))
            |=> rsp_q.rdata[FHV_HV_BIT] &&
                ((rsp_q.rdata == FHV_RSVD_DATA) == !$past(hv_flag_q) ||
                 $past(ctrl_byte) == FHV_RSVD_DATA))
        else $error("mode 3 top bit or byte wrong");

endmodule : fhv_gate

// ---- tb/fhv_supply_model.sv ----
// far-side model: programming supply and shared standby/supply pin
`timescale 1ns/1ps
module fhv_supply_model #(
    parameter int SETTLE = 4,
    parameter int RST_HOLD = 10
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic apply_hv,
    input wire logic sleep,
    output logic hv_detect,
    output logic standby_pin_n
);
    int cnt;
    int low_cnt;
    bit hv_level;
    logic may_move;

    // clocks spent in reset; a reset in mid-run must age before the supply moves
    always_ff @(posedge clk) begin
        if (nrst) begin
            low_cnt <= 0;
        end else if (low_cnt < RST_HOLD) begin
            low_cnt <= low_cnt + 1;
        end
    end

    // supply moves out of reset, or in a reset held long enough, never at reset entry
    assign may_move = nrst || (low_cnt >= RST_HOLD);

    // bit type starts low, so the supply is off at power-on without a reset branch
    always_ff @(posedge clk) begin
        if (!may_move || hv_level == apply_hv) begin
            cnt <= 0;
        end else if (cnt >= SETTLE) begin
            hv_level <= apply_hv;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end

    assign hv_detect = hv_level;
    assign standby_pin_n = ~sleep;
endmodule : fhv_supply_model

// ---- tb/fhv_gate_tb.sv ----
// self-checking bench for the flash control register gate
`timescale 1ns/1ps
module fhv_gate_tb;
    import fhv_pkg::*;
    logic clk, nrst, apply_hv, sleep, md1, md0, wmode;
    logic hv_detect, standby_pin_n, hv_flag_q, standby_q, prog_en_q, erase_en_q;
    fhv_req_t req;
    fhv_rsp_t rsp_q, got;
    int err_count, num_checks, cycles;
    // bench watchdog: bound on how long program or erase may stay set
    localparam int WDT_LIMIT = 200;
    int wdt_start;

    fhv_supply_model sup (.clk(clk), .nrst(nrst), .apply_hv(apply_hv), .sleep(sleep),
        .hv_detect(hv_detect), .standby_pin_n(standby_pin_n));

    fhv_gate uut (.clk(clk), .nrst(nrst), .hv_detect(hv_detect),
        .standby_pin_n(standby_pin_n), .mode_select_pin_1(md1), .mode_select_pin_0(md0),
        .writer_mode(wmode), .req(req), .rsp_q(rsp_q), .hv_flag_q(hv_flag_q),
        .standby_q(standby_q), .prog_en_q(prog_en_q), .erase_en_q(erase_en_q));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one idle cycle between requests keeps req single-assigned per step
    task automatic access(input logic rd, input logic [16:0] a, input logic [7:0] d);
        @(negedge clk);
        req <= '{rd: rd, wr: ~rd, addr: a, wdata: d};
        @(negedge clk);
        got = rsp_q;
        req <= '0;
    endtask : access

    task automatic rd_chk(input logic [16:0] a, input logic [10:0] exp);
        access(1'b1, a, 8'h00);
        check(got, exp);
    endtask : rd_chk

    task automatic set_pins(input logic [1:0] m, input logic hv, input logic s,
        input logic w);
        @(negedge clk);
        {md1, md0} <= m;
        apply_hv <= hv;
        sleep <= s;
        wmode <= w;
        repeat (10) @(negedge clk);
    endtask : set_pins

    task automatic print_verdict();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0;
        {apply_hv, sleep, wmode, md1, md0} = 5'b00011;
        req = '0;
        err_count = 0;
        num_checks = 0;
        cycles = 0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        access(1'b0, FHV_MODE_CTRL_ADDR, 8'h00);
        rd_chk(FHV_MODE_CTRL_ADDR, {3'b100, FHV_RSVD_DATA});
        set_pins(FHV_MODE3, 1'b1, 1'b0, 1'b0);
        check({10'h000, hv_flag_q}, 11'h001);
        rd_chk(FHV_MODE_CTRL_ADDR, {3'b100, FHV_MODE_CTRL_RST});
        access(1'b0, FHV_ERASE_LO_ADDR, 8'h3C);
        rd_chk(FHV_ERASE_LO_ADDR, {3'b100, 8'h3C});
        // reset in mid-run, held past ten clocks; the supply stays applied throughout
        @(negedge clk);
        nrst = 1'b0;
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (2) @(negedge clk);
        check({10'h000, hv_flag_q}, 11'h001);
        rd_chk(FHV_ERASE_LO_ADDR, {3'b100, FHV_ERASE_RST});
        rd_chk(FHV_MODE_CTRL_ADDR, {3'b100, FHV_MODE_CTRL_RST});
        access(1'b0, FHV_ERASE_LO_ADDR, 8'h5A);
        access(1'b0, FHV_ERASE_HI_ADDR, 8'hA5);
        rd_chk(FHV_ERASE_LO_ADDR, {3'b100, 8'h5A});
        rd_chk(FHV_ERASE_HI_ADDR, {3'b100, 8'hA5});
        wdt_start = cycles;
        access(1'b0, FHV_MODE_CTRL_ADDR, 8'h03);
        rd_chk(FHV_MODE_CTRL_ADDR, {3'b100, 8'h83});
        check({9'h000, prog_en_q, erase_en_q}, 11'h003);
        set_pins(FHV_MODE2, 1'b1, 1'b0, 1'b0);
        rd_chk(FHV_ERASE_LO_ADDR, {3'b100, 8'h5A});
        set_pins(FHV_MODE1, 1'b1, 1'b0, 1'b0);
        rd_chk(FHV_MODE_CTRL_ADDR, {3'b100, FHV_RSVD_DATA});
        access(1'b0, FHV_ERASE_HI_ADDR, 8'h00);
        check(got, 11'h400);
        set_pins(FHV_MODE3, 1'b1, 1'b0, 1'b0);
        rd_chk(FHV_ERASE_HI_ADDR, {3'b100, 8'hA5});
        // program and erase bits dropped before the supply moves
        access(1'b0, FHV_MODE_CTRL_ADDR, 8'h00);
        // enables follow the register one clock later
        @(negedge clk);
        check({9'h000, prog_en_q, erase_en_q}, 11'h000);
        check({10'h000, (cycles - wdt_start) > WDT_LIMIT}, 11'h000);
        for (int m = 1; m <= 2; m++) begin
            set_pins(m[1:0], 1'b0, 1'b0, 1'b0);
            check({10'h000, hv_flag_q}, 11'h000);
            access(1'b1, FHV_MODE_CTRL_ADDR, 8'h00);
            check({9'h000, got.valid, got.ext}, 11'h003);
        end
        set_pins(FHV_MODE3, 1'b0, 1'b0, 1'b1);
        rd_chk(FHV_MODE_CTRL_ADDR, {3'b100, FHV_RSVD_DATA});
        access(1'b1, FHV_BLANK_LO, 8'h00);
        check({3'b000, got.rdata}, {3'b000, FHV_RSVD_DATA});
        access(1'b1, FHV_BLANK_HI, 8'h00);
        check({3'b000, got.rdata}, {3'b000, FHV_RSVD_DATA});
        access(1'b1, 17'h07FFF, 8'h00);
        check({10'h000, got.mem}, 11'h001);
        set_pins(FHV_MODE3, 1'b0, 1'b1, 1'b1);
        check({10'h000, standby_q}, 11'h001);
        access(1'b1, FHV_MODE_CTRL_ADDR, 8'h00);
        check({10'h000, got.valid}, 11'h000);
        set_pins(FHV_MODE3, 1'b0, 1'b0, 1'b0);
        check({10'h000, standby_q}, 11'h000);
        print_verdict();
    end
endmodule : fhv_gate_tb
